/* async_serial_unit.sv */
// asynchronous serial unit: transmitter, receiver, baud chain
// assumes register master on ref_clk, rxd from another station
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`include "serial_params.svh"
module async_serial_unit (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire serial_pkg::reg_req_s req,
	output logic [7:0] rdata,
	input wire logic rxd,
	output logic txd
);
	// ---------------------------------------------------------
	// register state
	// ---------------------------------------------------------
	serial_pkg::ctrl_one_s c1_q;
	serial_pkg::ctrl_two_s c2_q;
	logic [5:0] baud_q;
	logic sleep_q;
	logic [7:0] tx_buf_q;
	logic [7:0] rx_buf_q;
	logic rx_ninth_bit_q;
	logic tdre_q, tc_q, full_q, idle_q, ovr_q, noise_q, fe_q;
	logic clr_arm_q;
	logic [7:0] rdata_q;

	wire wr_data = req.wr && req.addr == `OFS_DATA;
	wire wr_c1 = req.wr && req.addr == `OFS_CTRL_ONE;
	wire wr_c2 = req.wr && req.addr == `OFS_CTRL_TWO;
	wire wr_baud = req.wr && req.addr == `OFS_BAUD;
	wire rd_data = req.rd && req.addr == `OFS_DATA;
	wire rd_stat = req.rd && req.addr == `OFS_STATUS;
	wire rx_clr = rd_data && clr_arm_q;

	// ---------------------------------------------------------
	// baud chain: prescaler, optional /39, power-of-two rate
	// ---------------------------------------------------------
	logic [3:0] pre_cnt_q;
	logic [5:0] d39_cnt_q;
	logic [7:0] rate_cnt_q;
	wire [3:0] pre_last = baud_q[4:3] == 2'h0 ? `PRE_DIV_0 - 4'h1 :
		baud_q[4:3] == 2'h1 ? `PRE_DIV_1 - 4'h1 :
		baud_q[4:3] == 2'h2 ? `PRE_DIV_2 - 4'h1 : `PRE_DIV_3 - 4'h1;
	wire pre_tick = pre_cnt_q == pre_last;
	wire div39_en = baud_q[5];
	wire d39_tick = pre_tick && (!div39_en || d39_cnt_q == `DIV39_LAST); // R08
	wire [7:0] rate_mask = 8'((9'h001 << baud_q[2:0]) - 9'h001);
	wire tick16 = d39_tick && (rate_cnt_q & rate_mask) == rate_mask; // R07

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pre_cnt_q <= 4'h0;
			d39_cnt_q <= 6'h00;
			rate_cnt_q <= 8'h00;
		end else begin
			pre_cnt_q <= pre_tick ? 4'h0 : pre_cnt_q + 4'h1;
			if (pre_tick)
				d39_cnt_q <= d39_cnt_q == `DIV39_LAST ? 6'h00 : d39_cnt_q + 6'h01;
			if (d39_tick)
				rate_cnt_q <= rate_cnt_q + 8'h01;
		end
	end

	wire [3:0] frame_bits = c1_q.word9 ? `FRAME_BITS_9 : `FRAME_BITS_8; // R05
	wire [7:0] idle_samples = c1_q.word9 ? `IDLE_SAMPLES_9 : `IDLE_SAMPLES_8;

	// ---------------------------------------------------------
	// receive pin synchroniser
	// ---------------------------------------------------------
	logic rx_s1_q, rx_s2_q, rx_s3_q, rx_line_q;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_s1_q <= 1'b1;
			rx_s2_q <= 1'b1;
			rx_s3_q <= 1'b1;
			rx_line_q <= 1'b1;
		end else begin
			rx_s1_q <= rxd;
			rx_s2_q <= rx_s1_q;
			rx_s3_q <= rx_s2_q;
			if (rx_s2_q == rx_s3_q)
				rx_line_q <= rx_s3_q;
		end
	end

	// ---------------------------------------------------------
	// receiver
	// ---------------------------------------------------------
	serial_pkg::rx_state_e rx_st_q;
	logic [3:0] samp_q;
	logic [3:0] rbit_q;
	logic [1:0] vote_q;
	logic [8:0] rsh_q;
	logic rnoise_q;
	logic rx_prev_q;
	logic [7:0] idle_cnt_q;
	logic line_active_q;

	wire at_vote = tick16 && samp_q == `VOTE_C;
	wire maj = (vote_q[0] & vote_q[1]) | (vote_q[0] & rx_line_q) | (vote_q[1] & rx_line_q); // R12
	wire disagree = !(vote_q[0] == vote_q[1] && vote_q[1] == rx_line_q); // R24
	wire [3:0] last_bit = c1_q.word9 ? 4'h8 : 4'h7;
	wire fall = tick16 && rx_prev_q && !rx_line_q; // R01 R02
	wire stop_done = rx_st_q == serial_pkg::rx_stop && at_vote;
	wire frame_err = !maj;
	wire [8:0] rx_word = c1_q.word9 ? rsh_q : {1'b0, rsh_q[8:1]};
	wire can_flag = c2_q.rx_enable && !sleep_q; // R14
	wire rx_ovr_ev = stop_done && can_flag && full_q;
	wire rx_load = stop_done && can_flag && !full_q && !fe_q;
	wire addr_wake = rx_st_q == serial_pkg::rx_data && at_vote && rbit_q == last_bit &&
		maj && sleep_q && c1_q.wake_addr; // R18 R20 R21
	wire idle_hit = c2_q.rx_enable && tick16 && rx_line_q && line_active_q &&
		idle_cnt_q == idle_samples - 8'h01;
	wire idle_wake = idle_hit && sleep_q && !c1_q.wake_addr; // R16 R21

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_st_q <= serial_pkg::rx_hunt;
			samp_q <= 4'h0;
			rbit_q <= 4'h0;
			vote_q <= 2'h3;
			rsh_q <= 9'h000;
			rnoise_q <= 1'b0;
			rx_prev_q <= 1'b1;
		end else if (!c2_q.rx_enable) begin
			rx_st_q <= serial_pkg::rx_hunt;
			rx_prev_q <= 1'b1;
		end else if (tick16) begin
			rx_prev_q <= rx_line_q;
			samp_q <= samp_q + 4'h1;
			if (samp_q == `VOTE_A)
				vote_q[0] <= rx_line_q;
			if (samp_q == `VOTE_B)
				vote_q[1] <= rx_line_q;
			unique case (rx_st_q)
				serial_pkg::rx_hunt: begin
					if (fall) begin
						rx_st_q <= serial_pkg::rx_start;
						samp_q <= 4'h1;
					end
				end
				serial_pkg::rx_start: begin
					if (samp_q == `VOTE_C) begin
						rnoise_q <= disagree;
						rbit_q <= 4'h0;
						rx_st_q <= maj ? serial_pkg::rx_hunt : serial_pkg::rx_data; // R25
					end
				end
				serial_pkg::rx_data: begin
					if (samp_q == `VOTE_C) begin
						rsh_q <= {maj, rsh_q[8:1]}; // R03
						rnoise_q <= rnoise_q | disagree;
						rbit_q <= rbit_q + 4'h1;
					end
					if (samp_q == `OVERSAMPLE_LAST && rbit_q == last_bit + 4'h1)
						rx_st_q <= serial_pkg::rx_stop; // R04
				end
				serial_pkg::rx_stop: begin
					if (samp_q == `VOTE_C)
						rx_st_q <= serial_pkg::rx_hunt;
				end
			endcase
		end
	end

	// idle line detection: one full frame of high samples
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			idle_cnt_q <= 8'h00;
			line_active_q <= 1'b0;
		end else if (tick16) begin
			if (!rx_line_q || rx_st_q != serial_pkg::rx_hunt) begin
				idle_cnt_q <= 8'h00;
				line_active_q <= 1'b1;
			end else if (idle_hit) begin
				idle_cnt_q <= 8'h00;
				line_active_q <= 1'b0;
			end else if (idle_cnt_q != idle_samples) begin
				idle_cnt_q <= idle_cnt_q + 8'h01;
			end
		end
	end

	// receive buffer: whole word moved at stop bit
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_buf_q <= 8'h00;
			rx_ninth_bit_q <= 1'b0;
		end else if (rx_load) begin
			rx_buf_q <= rx_word[7:0]; // R11
			rx_ninth_bit_q <= rx_word[8]; // R23
		end
	end

	// receive flags: set wins over the read-sequence clear
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			full_q <= 1'b0;
			idle_q <= 1'b0;
			ovr_q <= 1'b0;
			noise_q <= 1'b0;
			fe_q <= 1'b0;
			clr_arm_q <= 1'b0;
		end else begin
			if (rd_stat)
				clr_arm_q <= 1'b1;
			else if (rd_data)
				clr_arm_q <= 1'b0;
			full_q <= rx_load | (full_q & !rx_clr); // R14
			ovr_q <= rx_ovr_ev | (ovr_q & !rx_clr);
			noise_q <= (rx_load & (rnoise_q | disagree)) | (noise_q & !rx_clr);
			fe_q <= (rx_load & frame_err) | (fe_q & !rx_clr); // R06
			idle_q <= (idle_hit & !sleep_q) | (idle_q & !rx_clr);
		end
	end

	// ---------------------------------------------------------
	// transmitter
	// ---------------------------------------------------------
	logic [3:0] tx_sub_q;
	logic [10:0] tsh_q;
	logic [3:0] tleft_q;
	logic tx_en_prev_q;
	logic pend_pre_q;
	logic txd_q;

	wire tx_bit = tick16 && tx_sub_q == `OVERSAMPLE_LAST; // R07
	wire tx_free = tleft_q == 4'h0;
	wire tx_rise = c2_q.tx_enable && !tx_en_prev_q;
	wire ld_pre = tx_bit && tx_free && c2_q.tx_enable && pend_pre_q;
	wire ld_brk = tx_bit && tx_free && c2_q.tx_enable && !pend_pre_q && c2_q.send_break;
	wire ld_dat = tx_bit && tx_free && c2_q.tx_enable && !pend_pre_q &&
		!c2_q.send_break && !tdre_q;
	wire [10:0] data_frame = {1'b1, c1_q.word9 ? c1_q.tx_ninth_bit : 1'b1,
		tx_buf_q, 1'b0}; // R02 R04 R23
	wire tx_done_ev = tx_bit && tx_free && !ld_pre && !ld_brk && !ld_dat;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_sub_q <= 4'h0;
			tsh_q <= 11'h7FF;
			tleft_q <= 4'h0;
			tx_en_prev_q <= 1'b0;
			pend_pre_q <= 1'b0;
			txd_q <= 1'b1;
		end else begin
			tx_en_prev_q <= c2_q.tx_enable;
			if (tick16)
				tx_sub_q <= tx_sub_q + 4'h1;
			if (tx_rise)
				pend_pre_q <= 1'b1; // R22
			else if (ld_pre)
				pend_pre_q <= 1'b0;
			if (tx_bit && !tx_free) begin
				txd_q <= tsh_q[0]; // R03 R10
				tsh_q <= {1'b1, tsh_q[10:1]};
				tleft_q <= tleft_q - 4'h1;
			end else if (ld_pre) begin
				tsh_q <= 11'h7FF; // R22
				tleft_q <= frame_bits;
			end else if (ld_brk) begin
				tsh_q <= 11'h000; // R06
				tleft_q <= frame_bits;
			end else if (ld_dat) begin
				tsh_q <= data_frame; // R09
				tleft_q <= frame_bits;
			end else if (tx_free && (tx_bit || !c2_q.tx_enable)) begin
				txd_q <= 1'b1; // R01
			end
		end
	end

	// transmit buffer and its flags; set wins over the clear
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_buf_q <= 8'h00;
			tdre_q <= 1'b1;
			tc_q <= 1'b1;
		end else begin
			if (wr_data)
				tx_buf_q <= req.wdata; // R09
			tdre_q <= ld_dat | (tdre_q & !wr_data);
			tc_q <= (tx_done_ev & !pend_pre_q) | (tc_q & !wr_data & !tx_rise);
		end
	end

	// ---------------------------------------------------------
	// control registers and sleep bit
	// ---------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			c1_q <= '0;
			c2_q <= '0;
			baud_q <= 6'h00;
			sleep_q <= 1'b0;
		end else begin
			if (wr_c1) begin
				c1_q.tx_ninth_bit <= req.wdata[6];
				c1_q.word9 <= req.wdata[4]; // R05
				c1_q.wake_addr <= req.wdata[3]; // R21
			end
			if (wr_c2) begin
				c2_q.tx_enable <= req.wdata[3];
				c2_q.rx_enable <= req.wdata[2];
				c2_q.send_break <= req.wdata[0];
			end
			if (wr_baud)
				baud_q <= req.wdata[5:0];
			if (wr_c2)
				sleep_q <= req.wdata[1]; // R13 R15
			else if (addr_wake || idle_wake)
				sleep_q <= 1'b0; // R16 R20
		end
	end

	// ---------------------------------------------------------
	// read side
	// ---------------------------------------------------------
	wire [7:0] c1_rd = {rx_ninth_bit_q, c1_q.tx_ninth_bit, 1'b0, c1_q.word9,
		c1_q.wake_addr, 3'h0};
	wire [7:0] c2_rd = {4'h0, c2_q.tx_enable, c2_q.rx_enable, sleep_q, c2_q.send_break};
	wire [7:0] st_rd = {tdre_q, tc_q, full_q, idle_q, ovr_q, noise_q, fe_q, 1'b0};
	wire [7:0] rd_mux = req.addr == `OFS_DATA ? rx_buf_q :
		req.addr == `OFS_CTRL_ONE ? c1_rd :
		req.addr == `OFS_CTRL_TWO ? c2_rd :
		req.addr == `OFS_STATUS ? st_rd :
		req.addr == `OFS_BAUD ? {2'h0, baud_q} : 8'h00;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			rdata_q <= 8'h00;
		else
			rdata_q <= req.rd ? rd_mux : 8'h00;
	end

	assign rdata = rdata_q;
	assign txd = txd_q; // R10
endmodule

/* serial_params.svh */
// constants for the asynchronous serial unit
// assumes a single 25 MHz clock and a plain register port
//
// Notes on behaviour
// R01 - line idles high; receiver hunts from high
// R02 - one low start bit opens each frame
// R03 - data bits travel least significant first
// R04 - start, eight or nine data, one stop
// R05 - word length bit sets both directions
// R06 - break is whole frames of low
// R07 - both paths share format and bit rate
// R08 - extra bit enables a divide-by-39 stage
// R09 - shifter loads only from the transmit buffer
// R10 - pin follows shifter while busy or enabled
// R11 - whole received word moves into buffer
// R12 - several samples per bit, majority vote
// R13 - writing one to sleep bit sleeps receiver
// R14 - sleeping receiver sets no receive flags
// R15 - software write can clear sleep bit
// R16 - idle line clears sleep in idle mode
// R17 - sender leaves idle frame between messages
// R18 - top data bit marks an address character
// R19 - sender starts messages with address character
// R20 - address character wakes before its stop bit
// R21 - wake select: zero idle, one address
// R22 - enabling transmitter queues one idle frame
// R23 - ninth bits live in dedicated bits
// R24 - sixteen samples per bit, three voted
// R25 - start confirmed only if low mid-bit
`ifndef SERIAL_PARAMS_SVH
`define SERIAL_PARAMS_SVH
`define OFS_DATA 3'h0
`define OFS_CTRL_ONE 3'h1
`define OFS_CTRL_TWO 3'h2
`define OFS_STATUS 3'h3
`define OFS_BAUD 3'h4
`define OVERSAMPLE_LAST 4'hF
`define VOTE_A 4'h7
`define VOTE_B 4'h8
`define VOTE_C 4'h9
`define FRAME_BITS_8 4'hA
`define FRAME_BITS_9 4'hB
`define IDLE_SAMPLES_8 8'hA0
`define IDLE_SAMPLES_9 8'hB0
`define DIV39_LAST 6'h26
`define PRE_DIV_0 4'h1
`define PRE_DIV_1 4'h3
`define PRE_DIV_2 4'h4
`define PRE_DIV_3 4'hD
`endif

/* serial_pkg.sv */
// types for the asynchronous serial unit
// assumes serial_params.svh for numeric constants
package serial_pkg;
	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} reg_req_s;
	typedef enum logic [1:0] {rx_hunt, rx_start, rx_data, rx_stop} rx_state_e;
	typedef struct packed {
		logic word9;
		logic wake_addr;
		logic tx_ninth_bit;
	} ctrl_one_s;
	typedef struct packed {
		logic tx_enable;
		logic rx_enable;
		logic send_break;
	} ctrl_two_s;
endpackage

/* serial_unit_props.sv */
// checker: port-level timing of the serial unit
// assumes bind onto async_serial_unit, baud left at its fastest rate
`timescale 1ns/1ps
module serial_unit_props (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire serial_pkg::reg_req_s req,
	input wire logic [7:0] rdata,
	input wire logic rxd,
	input wire logic txd
);
	logic txd_q;
	logic seen_q;
	logic armed_q;
	logic te_q;
	logic [3:0] gcnt_q;
	logic [7:0] pre_q;
	logic [7:0] hi_q;
	logic [6:0] c1_q;
	logic [3:0] c2_q;
	wire wr1 = req.wr && req.addr == 3'h1;
	wire wr2 = req.wr && req.addr == 3'h2;
	wire moved = txd != txd_q;
	wire te_rise = wr2 && req.wdata[3] && !te_q;
	wire arm = (req.wr && req.addr == 3'h0) || (wr2 && req.wdata[0]);
	// ------------------------------------------------
	// shadow state
	// ------------------------------------------------
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			txd_q <= 1'b1;
			seen_q <= 1'b0;
			armed_q <= 1'b0;
			gcnt_q <= 4'h0;
			pre_q <= 8'h00;
			hi_q <= 8'h00;
		end else begin
			txd_q <= txd;
			seen_q <= seen_q | moved;
			armed_q <= armed_q | arm;
			gcnt_q <= moved ? 4'h1 : gcnt_q + 4'h1;
			pre_q <= te_rise ? 8'hA0 : pre_q - {7'h00, pre_q != 8'h00};
			hi_q <= !txd ? 8'h00 : hi_q + {7'h00, hi_q != 8'hFF};
		end
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			te_q <= 1'b0;
			c1_q <= 7'h00;
			c2_q <= 4'h0;
		end else begin
			te_q <= wr2 ? req.wdata[3] : te_q;
			c1_q <= wr1 ? req.wdata[6:0] : c1_q;
			c2_q <= wr2 ? req.wdata[3:0] : c2_q;
		end
	end
	// ------------------------------------------------
	// properties
	// ------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);
	start_len_a: assert property ($fell(txd) |-> (!txd)[*8] ##1 (!txd)[*8])
		else $error("start bit too short");
	bit_grid_a: assert property (moved && seen_q |-> gcnt_q == 4'h0)
		else $error("txd edge off the bit grid");
	preamble_a: assert property (pre_q != 8'h00 |-> txd)
		else $error("no idle preamble");
	tx_off_a: assert property (!te_q && hi_q == 8'hFF |-> txd)
		else $error("txd moved while disabled");
	tx_armed_a: assert property ($fell(txd) |-> armed_q)
		else $error("frame without buffer load");
	rd_zero_a: assert property (!$past(req.rd) |-> rdata == 8'h00)
		else $error("read data outside its cycle");
	ctrl_one_a: assert property (req.rd && req.addr == 3'h1 |=> rdata[6:0] == {c1_q[6], 1'b0, c1_q[4:3], 3'h0})
		else $error("control one readback");
	ctrl_two_a: assert property (req.rd && req.addr == 3'h2 |=> {rdata[7:2], rdata[0]} == {4'h0, c2_q[3:2], c2_q[0]})
		else $error("control two readback");
endmodule
bind async_serial_unit serial_unit_props props_i (.ref_clk(ref_clk), .rst_n(rst_n), .req(req), .rdata(rdata),
	.rxd(rxd), .txd(txd));

/* line_station.sv */
// far-side station: drives rxd, decodes txd frames
// assumes sixteen clocks per bit on both lines
`timescale 1ns/1ps
module line_station (
	input wire logic ref_clk,
	input wire logic txd,
	output logic rxd
);
	logic nine;
	logic [9:0] got[$];
	logic [9:0] v;
	initial begin
		nine = 1'b0;
		rxd = 1'b1;
	end
	// low start, data lsb first, then stop level
	task automatic send(input logic [8:0] d, input logic stp);
		logic [10:0] f;
		f = nine ? {stp, d, 1'b0} : {1'b1, stp, d[7:0], 1'b0};
		for (int i = 0; i < 10 + nine; i++) begin
			rxd <= f[i];
			repeat (16) @(posedge ref_clk);
		end
		if (!stp) rxd <= 1'b1;
	endtask
	always begin
		@(negedge txd);
		repeat (8) @(posedge ref_clk);
		v = 10'h000;
		for (int i = 0; i < 9 + nine; i++) begin
			repeat (16) @(posedge ref_clk);
			v[i] = txd;
		end
		got.push_back(v);
	end
endmodule

/* tb.sv */
// testbench: directed register-level tests of the serial unit against the design
// assumes line_station on the far side and the bound checker
`timescale 1ns/1ps
module tb;
	logic ref_clk;
	logic rst_n;
	serial_pkg::reg_req_s req;
	logic [7:0] rdata;
	logic [7:0] rv;
	logic [7:0] b;
	logic rxd;
	logic txd;
	logic [31:0] lfsr_q;
	logic [9:0] exp_q[$];
	int error_cnt;
	int tests_run;
	int cyc;
	async_serial_unit DUT (.ref_clk(ref_clk), .rst_n(rst_n), .req(req), .rdata(rdata), .rxd(rxd), .txd(txd));
	line_station stn (.ref_clk(ref_clk), .txd(txd), .rxd(rxd));
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	function automatic logic [31:0] nxt(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		if (error_cnt == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic bus(input logic [2:0] a, input logic [7:0] d, input logic w);
		req <= serial_pkg::reg_req_s'{a, d, w, !w};
		@(posedge ref_clk);
		req <= '0;
		@(posedge ref_clk);
		rv = rdata;
	endtask
	task automatic poll(input logic [7:0] m);
		int n;
		n = 0;
		do begin
			bus(3'h3, 8'h00, 1'b0);
			n++;
		end while ((rv & m) !== m && n < 400);
		chk(rv & m, m);
	endtask
	task automatic flush();
		poll(8'h40);
		chk(10'(stn.got.size()), 10'(exp_q.size()));
		foreach (exp_q[i]) chk(stn.got[i], exp_q[i]);
		stn.got.delete();
		exp_q.delete();
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 60000) begin
			error_cnt++;
			wrap_up();
		end
	end
	initial begin
		req = '0;
		rst_n = 1'b0;
		lfsr_q = 32'h00AC;
		repeat (5) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		for (int a = 1; a < 8; a++) begin
			bus(3'(a), 8'h00, 1'b0);
			chk(rv, (a == 3) ? 8'hC0 : 8'h00);
		end
		bus(3'h4, 8'h20, 1'b1);
		bus(3'h4, 8'h00, 1'b0);
		chk(rv, 8'h20);
		bus(3'h4, 8'h00, 1'b1);
		repeat (260) @(posedge ref_clk);
		bus(3'h2, 8'h0C, 1'b1);
		repeat (3) begin
			poll(8'h80);
			lfsr_q = nxt(lfsr_q);
			bus(3'h0, lfsr_q[7:0], 1'b1);
			exp_q.push_back({2'b01, lfsr_q[7:0]});
		end
		flush();
		bus(3'h1, 8'h50, 1'b1);
		stn.nine = 1'b1;
		lfsr_q = nxt(lfsr_q);
		bus(3'h0, lfsr_q[7:0], 1'b1);
		exp_q.push_back({2'b11, lfsr_q[7:0]});
		flush();
		stn.send(9'h1A5, 1'b1);
		poll(8'h20);
		bus(3'h0, 8'h00, 1'b0);
		chk(rv, 8'hA5);
		bus(3'h1, 8'h00, 1'b0);
		chk(rv[7], 1'b1);
		bus(3'h1, 8'h00, 1'b1);
		stn.nine = 1'b0;
		lfsr_q = nxt(lfsr_q);
		b = lfsr_q[7:0];
		stn.send({1'b0, b}, 1'b1);
		stn.send({1'b0, ~b}, 1'b1);
		poll(8'h28);
		bus(3'h0, 8'h00, 1'b0);
		chk(rv, b);
		stn.send({1'b0, ~b}, 1'b1);
		poll(8'h20);
		chk(rv & 8'h04, 8'h00);
		bus(3'h0, 8'h00, 1'b0);
		chk(rv, 8'(~b));
		stn.send(9'h055, 1'b0);
		poll(8'h22);
		bus(3'h0, 8'h00, 1'b0);
		bus(3'h2, 8'h0E, 1'b1);
		stn.send(9'h03C, 1'b1);
		bus(3'h3, 8'h00, 1'b0);
		chk(rv & 8'h3E, 8'h00);
		repeat (200) @(posedge ref_clk);
		bus(3'h2, 8'h00, 1'b0);
		chk(rv[1], 1'b0);
		stn.send(9'h0C3, 1'b1);
		poll(8'h20);
		bus(3'h0, 8'h00, 1'b0);
		chk(rv, 8'hC3);
		bus(3'h1, 8'h08, 1'b1);
		bus(3'h2, 8'h0E, 1'b1);
		stn.send(9'h012, 1'b1);
		repeat (200) @(posedge ref_clk);
		bus(3'h2, 8'h00, 1'b0);
		chk(rv[1], 1'b1);
		stn.send(9'h085, 1'b1);
		poll(8'h20);
		bus(3'h0, 8'h00, 1'b0);
		chk(rv, 8'h85);
		bus(3'h1, 8'h00, 1'b1);
		bus(3'h2, 8'h0E, 1'b1);
		bus(3'h2, 8'h0C, 1'b1);
		bus(3'h2, 8'h00, 1'b0);
		chk(rv[1], 1'b0);
		bus(3'h2, 8'h0D, 1'b1);
		repeat (400) @(posedge ref_clk);
		bus(3'h2, 8'h0C, 1'b1);
		poll(8'h40);
		chk(stn.got[0], 10'h000);
		wrap_up();
	end
endmodule
